// file: core/tpo_trace_port_output_unit.sv
// Trace port output unit: trace bus slave, register slave, trace pins
// What this block does
// [RULE1] Beats carry one to four LSB-packed bytes
// [RULE2] Byte count field selects one to four bytes
// [RULE3] Ready high means presented beat accepted
// [RULE4] Flush request asks source to drain buffers
// [RULE5] Source acknowledges flush; request then dropped
// [RULE6] Single trace source, no merging
// [RULE7] Trace logic advances only when enabled; the trigger synchronizer stages shift every clock regardless
// [RULE8] Trace reset clears all trace logic
// [RULE9] External access bypasses the lock
// [RULE10] Only address bits 11 to 2 decoded
// [RULE11] Ready low inserts a wait state
// [RULE12] Register reset clears bus logic, registers
// [RULE13] Register logic advances only when enabled
// [RULE14] Pin clock divides core clock, data both edges
// [RULE15] Control pin marks triggers and idle cycles
// [RULE16] Width tie-off is width minus one
// [RULE17] Supported size register reflects width tie-off
// [RULE18] Narrow pad count set in tie-off
// [RULE19] Trigger input inserts trigger into stream
// [RULE20] Trigger input answered with acknowledge
// [RULE21] Reserved fields read as zero
// [RULE22] Held idle and not ready in reset
`timescale 1ns/1ps
`default_nettype none
`include "tpo_cfg.svh"

module tpo_trace_port_output_unit #(
    parameter int DATA_W = 32,
    parameter int WIDTH_W = 5
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic trace_bus_clock_enable,
    input wire logic [31:0] atb_data,
    input wire logic atb_valid,
    input wire logic [1:0] atb_bytes,
    output logic atb_ready,
    output logic flush_valid,
    input wire logic flush_ready,
    input wire logic reg_bus_reset_n,
    input wire logic reg_bus_clock_enable,
    input wire logic [11:2] reg_bus_address,
    input wire logic external_access_flag,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic reg_bus_ready,
    output logic exported_trace_clock,
    output logic [DATA_W-1:0] trace_pin_data,
    output logic trace_pin_control,
    input wire logic trigger_request_in,
    output logic trigger_request_ack,
    input wire logic [WIDTH_W-1:0] max_port_width_tieoff,
    input wire logic scan_shift_enable
);

    // Low bits mask for a width code of n minus one
    function automatic logic [31:0] width_mask(input logic [WIDTH_W-1:0] code);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = 0; i < 32; i++)
        begin
            m[i] = (i <= int'(code));
        end
        return m;
    endfunction

    // Fill every bit below the highest set bit
    function automatic logic [31:0] fill_down(input logic [31:0] v);
        logic [31:0] m;
        m = 32'h0000_0000;
        m[31] = v[31];
        for (int i = 30; i >= 0; i--)
        begin
            m[i] = v[i] | m[i+1];
        end
        return m;
    endfunction

    // Byte lane mask from a byte count code
    function automatic logic [31:0] byte_mask(input logic [1:0] cnt);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int b = 0; b < 4; b++)
        begin
            m[b*8 +: 8] = (b <= int'(cnt)) ? 8'hFF : 8'h00;
        end
        return m;
    endfunction

    // Register group state
    tpo_pkg::tpo_apb_state_t apb_state_reg, apb_state_next;
    logic [31:0] prdata_reg, prdata_next;
    logic ready_reg, ready_next;
    logic [31:0] cur_size_reg, cur_size_next;
    logic flush_req_reg, flush_req_next;
    logic flush_done_reg, flush_done_next;
    logic locked_reg, locked_next;

    // Trace group state
    tpo_pkg::tpo_beat_t beat_reg, beat_next;
    tpo_pkg::tpo_pin_t pin_reg, pin_next;
    logic atb_ready_reg, atb_ready_next;
    logic flush_valid_reg, flush_valid_next;
    logic tclk_reg, tclk_next;
    logic trig_s1_reg, trig_s2_reg, trig_s3_reg;
    logic trig_level_reg, trig_level_next;
    logic trig_pend_reg, trig_pend_next;
    logic ack_reg, ack_next;

    logic [31:0] supported;
    logic [31:0] rd_value;
    logic wr_ok;
    logic access;

    assign supported = width_mask(max_port_width_tieoff); // [RULE17]
    assign access = psel & penable;
    assign wr_ok = ~locked_reg | external_access_flag; // [RULE9]

    always_comb
    begin
        rd_value = 32'h0000_0000; // [RULE21]
        case ({reg_bus_address, 2'b00}) // [RULE10]
            `TPO_OFS_SUP_SIZE: rd_value = supported; // [RULE17]
            `TPO_OFS_CUR_SIZE: rd_value = cur_size_reg;
            `TPO_OFS_FLUSH_STAT:
            begin
                rd_value[`TPO_BIT_FLUSH_BUSY] = flush_valid_reg;
                rd_value[`TPO_BIT_FLUSH_DONE] = flush_done_reg;
            end
            `TPO_OFS_FLUSH_CTRL: rd_value[`TPO_BIT_FLUSH_REQ] = flush_req_reg;
            `TPO_OFS_LOCK_STAT:
            begin
                rd_value[`TPO_BIT_LOCK_IMPL] = 1'b1;
                rd_value[`TPO_BIT_LOCKED] = locked_reg & ~external_access_flag;
            end
            default: rd_value = 32'h0000_0000;
        endcase
    end

    // Register group next values
    always_comb
    begin
        apb_state_next = apb_state_reg;
        prdata_next = prdata_reg;
        ready_next = ready_reg;
        cur_size_next = cur_size_reg;
        flush_req_next = flush_req_reg;
        flush_done_next = flush_done_reg;
        locked_next = locked_reg;
        if (reg_bus_clock_enable) // [RULE13]
        begin
            if (flush_valid_reg & flush_ready)
            begin
                flush_done_next = 1'b1;
                flush_req_next = 1'b0; // [RULE5]
            end
            case (apb_state_reg)
                tpo_pkg::TPO_APB_SETUP:
                begin
                    ready_next = 1'b0;
                    if (access)
                    begin
                        ready_next = 1'b1; // [RULE11]
                        prdata_next = pwrite ? 32'h0000_0000 : rd_value;
                        apb_state_next = tpo_pkg::TPO_APB_DONE;
                    end
                end
                tpo_pkg::TPO_APB_DONE:
                begin
                    ready_next = 1'b0;
                    apb_state_next = tpo_pkg::TPO_APB_SETUP;
                    if (access & pwrite)
                    begin
                        if ({reg_bus_address, 2'b00} == `TPO_OFS_LOCK_KEY)
                        begin
                            locked_next = (pwdata != `TPO_LOCK_KEY_VAL);
                        end
                        else if (wr_ok) // [RULE9]
                        begin
                            case ({reg_bus_address, 2'b00})
                                `TPO_OFS_CUR_SIZE:
                                begin
                                    if ((pwdata & ~supported) == 32'h0000_0000 && pwdata != 32'h0000_0000)
                                    begin
                                        cur_size_next = pwdata;
                                    end
                                end
                                `TPO_OFS_FLUSH_CTRL:
                                begin
                                    if (pwdata[`TPO_BIT_FLUSH_REQ] & ~flush_req_reg)
                                    begin
                                        flush_req_next = 1'b1;
                                        flush_done_next = 1'b0;
                                    end
                                end
                                `TPO_OFS_FLUSH_STAT:
                                begin
                                    if (pwdata[`TPO_BIT_FLUSH_DONE] & ~(flush_valid_reg & flush_ready))
                                    begin
                                        flush_done_next = 1'b0;
                                    end
                                end
                                default: cur_size_next = cur_size_reg;
                            endcase
                        end
                    end
                end
                default: apb_state_next = tpo_pkg::TPO_APB_SETUP;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reg_bus_reset_n)
    begin
        if (!reg_bus_reset_n) // [RULE12]
        begin
            apb_state_reg <= tpo_pkg::TPO_APB_SETUP;
            prdata_reg <= 32'h0000_0000;
            ready_reg <= 1'b0;
            cur_size_reg <= `TPO_CUR_SIZE_RST;
            flush_req_reg <= 1'b0;
            flush_done_reg <= 1'b0;
            locked_reg <= 1'b1;
        end
        else
        begin
            apb_state_reg <= apb_state_next;
            prdata_reg <= prdata_next;
            ready_reg <= ready_next;
            cur_size_reg <= cur_size_next;
            flush_req_reg <= flush_req_next;
            flush_done_reg <= flush_done_next;
            locked_reg <= locked_next;
        end
    end

    // Trace group next values
    logic [31:0] out_mask;
    logic accept;
    logic rise;

    assign out_mask = supported & fill_down(cur_size_reg);
    assign accept = atb_valid & atb_ready_reg & trace_bus_clock_enable; // [RULE3] [RULE6]

    always_comb
    begin
        beat_next = beat_reg;
        pin_next = pin_reg;
        tclk_next = tclk_reg;
        trig_level_next = trig_level_reg;
        trig_pend_next = trig_pend_reg;
        ack_next = ack_reg;
        flush_valid_next = flush_valid_reg;
        rise = 1'b0;
        if (trace_bus_clock_enable) // [RULE7]
        begin
            if (trig_s2_reg == trig_s3_reg)
            begin
                trig_level_next = trig_s3_reg;
            end
            tclk_next = ~tclk_reg; // [RULE14]
            flush_valid_next = flush_req_reg & ~(flush_valid_reg & flush_ready); // [RULE4] [RULE5]
            rise = trig_level_next & ~trig_level_reg;
            if (trig_pend_reg)
            begin
                pin_next.ctl = 1'b1; // [RULE15] [RULE19]
                pin_next.data = `TPO_TRIG_MARK & out_mask;
                trig_pend_next = rise;
                ack_next = 1'b1; // [RULE20]
            end
            else if (beat_reg.valid)
            begin
                pin_next.ctl = 1'b0;
                pin_next.data = beat_reg.data & byte_mask(beat_reg.bytes) & out_mask; // [RULE1] [RULE2]
                beat_next.valid = 1'b0;
                trig_pend_next = rise;
            end
            else
            begin
                pin_next.ctl = 1'b1; // [RULE15]
                pin_next.data = `TPO_IDLE_DATA;
                trig_pend_next = rise;
            end
            if (!trig_level_next)
            begin
                ack_next = 1'b0;
            end
            if (accept)
            begin
                beat_next.valid = 1'b1; // [RULE3]
                beat_next.bytes = atb_bytes;
                beat_next.data = atb_data;
            end
        end
        atb_ready_next = ~beat_next.valid;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n) // [RULE8] [RULE22]
        begin
            beat_reg <= '0;
            pin_reg <= '{ctl: 1'b1, data: `TPO_IDLE_DATA};
            tclk_reg <= 1'b0;
            atb_ready_reg <= 1'b0;
            flush_valid_reg <= 1'b0;
            trig_s1_reg <= 1'b0;
            trig_s2_reg <= 1'b0;
            trig_s3_reg <= 1'b0;
            trig_level_reg <= 1'b0;
            trig_pend_reg <= 1'b0;
            ack_reg <= 1'b0;
        end
        else
        begin
            beat_reg <= beat_next;
            pin_reg <= pin_next;
            tclk_reg <= tclk_next;
            atb_ready_reg <= atb_ready_next;
            flush_valid_reg <= flush_valid_next;
            trig_s1_reg <= trigger_request_in;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
            trig_level_reg <= trig_level_next;
            trig_pend_reg <= trig_pend_next;
            ack_reg <= ack_next;
        end
    end

    assign atb_ready = atb_ready_reg;
    assign flush_valid = flush_valid_reg;
    assign prdata = prdata_reg;
    assign reg_bus_ready = ready_reg;
    assign exported_trace_clock = tclk_reg;
    assign trace_pin_data = pin_reg.data[DATA_W-1:0];
    assign trace_pin_control = pin_reg.ctl;
    assign trigger_request_ack = ack_reg;

endmodule // tpo_trace_port_output_unit
`default_nettype wire

// file: shared/tpo_cfg.svh
// Constants for the trace port output unit
`ifndef TPO_CFG_SVH
`define TPO_CFG_SVH
`define TPO_OFS_SUP_SIZE 12'h000
`define TPO_OFS_CUR_SIZE 12'h004
`define TPO_OFS_FLUSH_STAT 12'h300
`define TPO_OFS_FLUSH_CTRL 12'h304
`define TPO_OFS_LOCK_KEY 12'hFB0
`define TPO_OFS_LOCK_STAT 12'hFB4
`define TPO_CUR_SIZE_RST 32'h0000_0001
`define TPO_LOCK_KEY_VAL 32'h5A5A_1234
`define TPO_TRIG_MARK 32'h0000_00FF
`define TPO_IDLE_DATA 32'h0000_0000
`define TPO_BIT_FLUSH_REQ 0
`define TPO_BIT_FLUSH_BUSY 0
`define TPO_BIT_FLUSH_DONE 1
`define TPO_BIT_LOCK_IMPL 0
`define TPO_BIT_LOCKED 1
`endif

// file: shared/tpo_pkg.sv
// Types for the trace port output unit
package tpo_pkg;
    typedef struct packed {
        logic valid;
        logic [1:0] bytes;
        logic [31:0] data;
    } tpo_beat_t;
    typedef struct packed {
        logic ctl;
        logic [31:0] data;
    } tpo_pin_t;
    typedef enum logic [0:0] {
        TPO_APB_SETUP = 1'b0,
        TPO_APB_DONE = 1'b1
    } tpo_apb_state_t;
endpackage

// file: verif/tpo_pin_capture.sv
// Capture model of the external trace analyzer
`timescale 1ns/1ps
`default_nettype none
module tpo_pin_capture (
    input wire logic ref_clk,
    input wire logic exported_trace_clock,
    input wire logic trace_pin_control,
    input wire logic [31:0] trace_pin_data
);
    logic last_clk = 1'b0;
    logic [31:0] words[$];
    int trigs = 0;
    // Sample on every pin clock transition
    always @(posedge ref_clk)
    begin
        if (exported_trace_clock !== last_clk)
        begin
            last_clk = exported_trace_clock;
            if (trace_pin_control === 1'b0)
                words.push_back(trace_pin_data);
            else if (trace_pin_data === 32'h0000_00FF)
                trigs++;
        end
    end
endmodule // tpo_pin_capture
`default_nettype wire

// file: verif/tpo_port_chk.sv
// Port assertions for the trace port output unit
`timescale 1ns/1ps
`default_nettype none
module tpo_port_chk #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic trace_bus_clock_enable,
    input wire logic atb_valid,
    input wire logic atb_ready,
    input wire logic flush_valid,
    input wire logic flush_ready,
    input wire logic reg_bus_reset_n,
    input wire logic reg_bus_clock_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic reg_bus_ready,
    input wire logic exported_trace_clock,
    input wire logic [DATA_W-1:0] trace_pin_data,
    input wire logic trace_pin_control,
    input wire logic trigger_request_in,
    input wire logic trigger_request_ack
);
    a_beat_taken: assert property (@(posedge ref_clk) disable iff (!arst_n)
        atb_valid && atb_ready && trace_bus_clock_enable |=>
        !atb_ready and (trace_bus_clock_enable |=> !trace_pin_control))
        else $error("beat acceptance wrong");
    a_hold_disabled: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !trace_bus_clock_enable |=> $stable(exported_trace_clock) && $stable(trace_pin_data) && $stable(atb_ready))
        else $error("trace outputs moved while disabled");
    a_pin_clock: assert property (@(posedge ref_clk) disable iff (!arst_n)
        trace_bus_clock_enable |=> exported_trace_clock != $past(exported_trace_clock))
        else $error("pin clock did not toggle");
    a_wait_state: assert property (@(posedge ref_clk) disable iff (!reg_bus_reset_n)
        psel && penable && !reg_bus_ready && reg_bus_clock_enable |-> ##[1:2] reg_bus_ready)
        else $error("register access not answered");
    a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!reg_bus_reset_n)
        reg_bus_ready && reg_bus_clock_enable |=> !reg_bus_ready)
        else $error("ready held too long");
    a_ready_cause: assert property (@(posedge ref_clk) disable iff (!reg_bus_reset_n)
        $rose(reg_bus_ready) |-> $past(psel && penable && reg_bus_clock_enable))
        else $error("ready without access");
    a_flush_drop: assert property (@(posedge ref_clk) disable iff (!arst_n)
        flush_valid && flush_ready |-> ##[1:8] !flush_valid)
        else $error("flush request not dropped");
    a_trig_ack: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $rose(trigger_request_in) |-> ##[2:40] trigger_request_ack)
        else $error("trigger not acknowledged");
    a_ack_release: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(trigger_request_in) |-> ##[1:8] !trigger_request_ack)
        else $error("acknowledge not released");
    a_reset_idle: assert property (@(posedge ref_clk)
        !arst_n |-> !atb_ready && !flush_valid && trace_pin_control && !trigger_request_ack)
        else $error("outputs not idle in reset");
endmodule // tpo_port_chk
bind tpo_trace_port_output_unit tpo_port_chk #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

// file: verif/tpo_trace_port_output_unit_tb.sv
// Testbench for the trace port output unit
`timescale 1ns/1ps
`default_nettype none
module tpo_trace_port_output_unit_tb;
    logic ref_clk = 0, arst_n = 1, reg_bus_reset_n = 1, trace_bus_clock_enable = 1, reg_bus_clock_enable = 1;
    logic atb_valid = 0, flush_ready = 0, external_access_flag = 0, psel = 0, penable = 0, pwrite = 0;
    logic trigger_request_in = 0, scan_shift_enable = 0, rnd_en = 0;
    logic atb_ready, flush_valid, reg_bus_ready, exported_trace_clock, trace_pin_control, trigger_request_ack;
    logic [31:0] atb_data = 32'h0, pwdata = 32'h0, prdata, trace_pin_data, rd;
    logic [31:0] exp_q[$];
    logic [1:0] atb_bytes = 2'h0;
    logic [11:2] reg_bus_address = 10'h0;
    logic [4:0] max_port_width_tieoff = 5'h1F;
    int seed = 42435, error_cnt = 0, n_tests = 0, cyc = 0, k;

    tpo_trace_port_output_unit #(.DATA_W(32), .WIDTH_W(5)) dut (.*);
    tpo_pin_capture cap (.ref_clk, .exported_trace_clock, .trace_pin_control, .trace_pin_data);

    initial
    begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk)
    begin
        trace_bus_clock_enable <= rnd_en ? ($random(seed) % 3 != 0) : 1'b1;
        reg_bus_clock_enable <= rnd_en ? ($random(seed) % 2 == 0) : 1'b1;
    end

    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            wrap_up();
        end
    end

    task wrap_up;
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic x);
        @(negedge ref_clk);
        psel = 1;
        pwrite = w;
        reg_bus_address = a[11:2];
        pwdata = d;
        external_access_flag = x;
        @(negedge ref_clk);
        penable = 1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (!(reg_bus_ready === 1'b1 && reg_bus_clock_enable === 1'b1) && k < 20);
        rd = prdata;
        chk("reg_bus_ready", 1, reg_bus_ready & reg_bus_clock_enable);
        @(negedge ref_clk);
        psel = 0;
        penable = 0;
        external_access_flag = 0;
    endtask

    task rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(a, 0, 32'h0, 0);
        chk("prdata", e, rd);
    endtask

    // One beat with random byte count, model keeps the lane-masked word
    task beat;
        logic [1:0] b;
        @(negedge ref_clk);
        b = $random(seed);
        atb_bytes = b;
        atb_data = $random(seed);
        atb_valid = 1;
        k = 0;
        do
        begin
            @(posedge ref_clk);
            k++;
        end
        while (!(atb_ready === 1'b1 && trace_bus_clock_enable === 1'b1) && k < 50);
        chk("atb_accept", 1, atb_ready & trace_bus_clock_enable);
        exp_q.push_back(atb_data & (b == 2'h3 ? 32'hFFFF_FFFF : (32'h1 << (8 * (b + 1))) - 1));
        @(negedge ref_clk);
        atb_valid = 0;
    endtask

    initial
    begin
        @(negedge ref_clk);
        arst_n = 0;
        reg_bus_reset_n = 0;
        idle(6);
        arst_n = 1;
        reg_bus_reset_n = 1;
        rdchk(12'h000, 32'hFFFF_FFFF);
        rdchk(12'h004, 32'h0000_0001);
        rdchk(12'hFB4, 32'h0000_0003);
        rdchk(12'h100, 32'h0000_0000);
        apb(12'h304, 1, 32'h0000_0001, 0);
        idle(4);
        chk("flush_valid", 0, flush_valid);
        apb(12'h304, 1, 32'h0000_0001, 1);
        idle(4);
        chk("flush_valid", 1, flush_valid);
        flush_ready = 1;
        idle(8);
        chk("flush_valid", 0, flush_valid);
        rdchk(12'h300, 32'h0000_0002);
        apb(12'h304, 1, 32'h0000_0000, 1);
        flush_ready = 0;
        rnd_en = 1;
        apb(12'h004, 1, 32'h8000_0000, 1);
        rdchk(12'h004, 32'h8000_0000);
        repeat (40) beat();
        rnd_en = 0;
        idle(10);
        chk("beat_count", 40, cap.words.size());
        foreach (exp_q[i]) chk("pin_data", exp_q[i], cap.words[i]);
        trigger_request_in = 1;
        k = 0;
        while (trigger_request_ack !== 1'b1 && k < 40)
        begin
            @(negedge ref_clk);
            k++;
        end
        idle(3);
        chk("trig_ack", 1, trigger_request_ack);
        chk("trig_marks", 1, cap.trigs);
        trigger_request_in = 0;
        idle(10);
        chk("trig_ack", 0, trigger_request_ack);
        arst_n = 0;
        idle(2);
        chk("pin_ctl", 1, trace_pin_control);
        chk("atb_ready", 0, atb_ready);
        arst_n = 1;
        beat();
        idle(6);
        chk("pin_data", exp_q[$], cap.words[$]);
        max_port_width_tieoff = 5'h0F;
        rdchk(12'h000, 32'h0000_FFFF);
        beat();
        idle(6);
        chk("narrow_data", exp_q[$] & 32'h0000_FFFF, cap.words[$]);
        wrap_up();
    end
endmodule // tpo_trace_port_output_unit_tb
`default_nettype wire
